// >>> pisb_pkg.sv
package pisb_pkg;
    // Host expansion-bus port carrying the keys (write) and status (read) view
    localparam logic [9:0]  KEYS_PORT     = 10'h166;
    localparam int          KEY_H2P_SET   = 0;
    localparam int          KEY_P2H_SET   = 1;
    localparam int          KEY_P2H_CLR   = 2;
    localparam int          STAT_H2P      = 0;
    localparam int          STAT_P2H      = 1;

    // Program levels
    localparam logic [3:0]  LVL_TERM_OUT  = 4'ha;
    localparam logic [3:0]  LVL_DMA       = 4'hb;
    localparam logic [3:0]  LVL_TERM_IN   = 4'hc;
    localparam logic [3:0]  LVL_RTC       = 4'hd;
    localparam logic [3:0]  LVL_INTERNAL  = 4'he;
    localparam logic [3:0]  LVL_TOP       = 4'hf;

    // Normal-group sources, lowest priority first
    localparam int          SRC_CONSOLE   = 0;
    localparam int          SRC_MAILBOX   = 1;
    localparam int          SRC_SERIAL    = 2;
    localparam int          SRC_DMA       = 3;
    localparam int          SRC_ALU       = 4;
    localparam int          SRC_PARITY    = 5;
    localparam int          SRC_OOR       = 6;
    localparam int          SRC_POWER     = 7;

    // Panel-group vector offsets
    localparam int          PAN_STOP      = 0;
    localparam int          PAN_RTC       = 2;
    localparam int          PAN_MCL       = 7;

    localparam logic [4:0]  SEL_NORMAL    = 5'h0a;
    localparam logic [4:0]  SEL_PANEL     = 5'h0b;
    localparam logic [11:0] NORMAL_VECTOR_BASE = 12'h100;
    localparam logic [11:0] PANEL_VECTOR_BASE  = 12'h140;

    localparam logic [1:0]  ROUTE_CPU     = 2'h0;
    localparam logic [1:0]  ROUTE_LINK    = 2'h1;
    localparam logic [1:0]  ROUTE_MAILBOX = 2'h2;

    // Host controller AXI4-Lite map
    localparam logic [7:0]  REG_CMD       = 8'h00;
    localparam logic [7:0]  REG_STATUS    = 8'h04;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {H_IDLE, H_WRITE, H_READ, H_CAPT} pisb_hstate_t;

    // Highest set bit: {valid, index}
    function automatic logic [4:0] pisb_top16(input logic [15:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction : pisb_top16
endpackage : pisb_pkg

// >>> pisb_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pisb_if;
    logic [9:0] io_addr;
    logic       io_wr;
    logic       io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic       irq5;

    modport dev (
        input  io_addr, io_wr, io_rd, io_wdata,
        output io_rdata, irq5
    );
    modport host (
        output io_addr, io_wr, io_rd, io_wdata,
        input  io_rdata, irq5
    );
endinterface : pisb_if
`default_nettype wire

// >>> pisb_device.sv
`timescale 1ns/100ps
`default_nettype none
module pisb_device
    import pisb_pkg::*;
(
    input  wire logic        aclk,                   // System clock
    input  wire logic        aresetn,                // Sync reset, low
    pisb_if.dev              bus,                    // Host expansion bus
    input  wire logic [3:0]  ext_req,                // Levels 10..13 pulses
    input  wire logic [7:0]  normal_src,             // Normal sources, bit 1 unused
    input  wire logic        run,                    // Processor running
    input  wire logic        rtc_tick,               // 20 ms clock pulse
    input  wire logic        master_clear_switch,    // Panel switch
    input  wire logic        stop_mode,              // Panel in stop mode
    input  wire logic [15:0] sw_detect_set,          // Microcode detect set
    input  wire logic        enable_wr,              // Load enable bits
    input  wire logic [15:0] enable_data,            // New enable bits
    input  wire logic        level_check,            // Level change check
    input  wire logic        wait_cmd,               // Wait executed
    input  wire logic        ident_cmd,              // Identify
    input  wire logic        device_io_command,      // Device command
    input  wire logic [2:0]  dev_sel,                // Device of command
    input  wire logic        trap_ack,               // Trap taken
    input  wire logic        idb_read,               // Source read strobe
    input  wire logic [4:0]  bus_source_select,      // Source decode
    input  wire logic        proc_clears_h2p,        // Drop host flag
    input  wire logic        proc_resets_h2p,        // Re-raise host flag
    input  wire logic        proc_sets_p2h,          // Raise processor flag
    output logic [3:0]       current_level_register, // Current level
    output logic             level_change,           // Level changed pulse
    output logic [15:0]      level_detect_bits,      // Detect bits
    output logic [15:0]      level_enable_bits,      // Enable bits
    output logic             interrupt_request_ff,   // Request flip-flop
    output logic [11:0]      trap_vector,            // Absolute vector
    output logic [3:0]       ident_code,             // Identified source
    output logic [7:0]       idb_data,               // Source read data
    output logic [1:0]       service_route,          // Service owner
    output logic             host_to_proc_flag,      // Mailbox flag
    output logic             proc_to_host_flag       // Flag toward host
);
    logic [7:0]  dev_pend;
    logic [7:0]  dev_en;
    logic [7:0]  pan_pend;
    logic [7:0]  rdata_q;
    logic [3:0]  next_cur;
    logic        next_change;
    logic [15:0] next_detect;
    logic [15:0] next_enable;
    logic        next_irq_ff;
    logic [11:0] next_vector;
    logic [3:0]  next_ident;
    logic [7:0]  next_idb;
    logic [1:0]  next_route;
    logic        next_h2p;
    logic        next_p2h;
    logic [7:0]  next_pend;
    logic [7:0]  next_dev_en;
    logic [7:0]  next_pan;
    logic [7:0]  next_rdata;

    logic        keys_wr;
    logic        int_any;
    logic [7:0]  normal_act;
    logic [4:0]  ltop;
    logic [4:0]  wtop;
    logic [4:0]  ntop;
    logic [4:0]  ptop;
    logic        panel_group_request;
    logic        gated_panel_request;
    logic        normal_group_request;
    logic [15:0] detect_set;
    logic [15:0] detect_clr;
    // Panel switch is asynchronous, two stages before use
    logic        mcl_meta;
    logic        mcl_sync;

    assign bus.io_rdata = rdata_q;
    assign bus.irq5     = proc_to_host_flag;

    always_comb begin
        keys_wr = bus.io_wr && (bus.io_addr == KEYS_PORT);

        // Signal box flags, a set in the clearing cycle survives
        next_h2p = (keys_wr && bus.io_wdata[KEY_H2P_SET])
                 || proc_resets_h2p
                 || (host_to_proc_flag && !proc_clears_h2p);
        next_p2h = proc_sets_p2h
                 || (keys_wr && bus.io_wdata[KEY_P2H_SET])
                 || (proc_to_host_flag
                     && !(keys_wr && bus.io_wdata[KEY_P2H_CLR]));
        next_rdata = rdata_q;
        if (bus.io_rd && bus.io_addr == KEYS_PORT) begin
            next_rdata = 8'h00;
            next_rdata[STAT_H2P] = host_to_proc_flag;
            next_rdata[STAT_P2H] = proc_to_host_flag;
        end

        // Level detect: ext 10..13, internal on 14, rest by microcode
        int_any = normal_src[SRC_ALU] || normal_src[SRC_PARITY]
                || normal_src[SRC_OOR] || normal_src[SRC_POWER];
        detect_set = sw_detect_set | {1'b0, int_any, ext_req, 10'h000};
        detect_clr = wait_cmd ? (16'h0001 << current_level_register) : 16'h0000;
        next_detect = detect_set | (level_detect_bits & ~detect_clr);
        next_enable = enable_wr ? enable_data : level_enable_bits;

        ltop = pisb_top16(level_detect_bits & level_enable_bits);
        wtop = pisb_top16(next_detect & next_enable);
        next_cur    = current_level_register;
        next_change = 1'b0;
        if (wait_cmd) begin
            next_cur = wtop[4] ? wtop[3:0] : 4'h0;
        end else if (level_check && ltop[4]
                     && ltop[3:0] > current_level_register) begin
            next_cur    = ltop[3:0];
            next_change = 1'b1;
        end

        // Normal group, mailbox follows its flag directly
        next_pend  = (normal_src & 8'hfd) | dev_pend;
        normal_act = {dev_pend[7:2], host_to_proc_flag, dev_pend[0]} & dev_en;
        ntop = pisb_top16({8'h00, normal_act});
        next_dev_en = dev_en;
        next_ident  = ident_code;
        if (ident_cmd && ntop[4]) begin
            next_ident = ntop[3:0];
            next_dev_en[ntop[2:0]] = 1'b0;
        end
        if (device_io_command) begin
            next_dev_en[dev_sel] = 1'b1;
            if (!normal_src[dev_sel]) begin
                next_pend[dev_sel] = 1'b0;
            end
        end

        // Panel group; the stop bit stays while run is low
        next_pan = pan_pend;
        next_pan[PAN_STOP] = pan_pend[PAN_STOP] || !run;
        next_pan[PAN_RTC]  = pan_pend[PAN_RTC] || rtc_tick;
        next_pan[PAN_MCL]  = pan_pend[PAN_MCL] || mcl_sync;
        ptop = pisb_top16({8'h00, pan_pend});

        panel_group_request  = |pan_pend;
        normal_group_request = |normal_act;
        gated_panel_request  = panel_group_request && !stop_mode;
        next_irq_ff = normal_group_request || gated_panel_request
                    || (interrupt_request_ff && !trap_ack);
        next_vector = gated_panel_request ? PANEL_VECTOR_BASE
                                          : NORMAL_VECTOR_BASE;

        next_idb   = idb_data;
        next_route = service_route;
        if (idb_read) begin
            case (bus_source_select)
                SEL_NORMAL: begin
                    next_idb = {ntop[4], 3'h0, ntop[3:0]};
                    if (ntop[2:0] == 3'(SRC_MAILBOX)) begin
                        next_route = ROUTE_MAILBOX;
                    end else if (ntop[2:0] == 3'(SRC_SERIAL)
                                 || ntop[2:0] == 3'(SRC_DMA)) begin
                        next_route = ROUTE_LINK;
                    end else begin
                        next_route = ROUTE_CPU;
                    end
                end
                SEL_PANEL: begin
                    next_idb = {ptop[4], 3'h0, ptop[3:0]};
                    // Reading consumes the panel event unless it re-fires
                    if (ptop[4]) begin
                        next_pan[ptop[2:0]] = (ptop[2:0] == 3'(PAN_STOP)) ? !run
                                            : (ptop[2:0] == 3'(PAN_RTC)) ? rtc_tick
                                            : mcl_sync;
                    end
                end
                default: begin
                    next_idb = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            current_level_register <= 4'h0;
            level_change           <= 1'b0;
            level_detect_bits      <= 16'h0000;
            level_enable_bits      <= 16'h0000;
            interrupt_request_ff   <= 1'b0;
            trap_vector            <= NORMAL_VECTOR_BASE;
            ident_code             <= 4'h0;
            idb_data               <= 8'h00;
            service_route          <= ROUTE_CPU;
            host_to_proc_flag      <= 1'b0;
            proc_to_host_flag      <= 1'b0;
            dev_pend               <= 8'h00;
            dev_en                 <= 8'hff;
            pan_pend               <= 8'h00;
            rdata_q                <= 8'h00;
            mcl_meta               <= 1'b0;
            mcl_sync               <= 1'b0;
        end else begin
            current_level_register <= next_cur;
            level_change           <= next_change;
            level_detect_bits      <= next_detect;
            level_enable_bits      <= next_enable;
            interrupt_request_ff   <= next_irq_ff;
            trap_vector            <= next_vector;
            ident_code             <= next_ident;
            idb_data               <= next_idb;
            service_route          <= next_route;
            host_to_proc_flag      <= next_h2p;
            proc_to_host_flag      <= next_p2h;
            dev_pend               <= next_pend;
            dev_en                 <= next_dev_en;
            pan_pend               <= next_pan;
            rdata_q                <= next_rdata;
            mcl_meta               <= master_clear_switch;
            mcl_sync               <= mcl_meta;
        end
    end
endmodule : pisb_device
`default_nettype wire

// >>> pisb_host.sv
`timescale 1ns/100ps
`default_nettype none
module pisb_host
    import pisb_pkg::*;
(
    input  wire logic        aclk,          // System clock
    input  wire logic        aresetn,       // Sync reset, low
    pisb_if.host             bus,           // Expansion bus to device
    input  wire logic [7:0]  s_awaddr,      // AXI write address
    input  wire logic        s_awvalid,     // AXI
    output logic             s_awready,     // AXI
    input  wire logic [31:0] s_wdata,       // AXI write data
    input  wire logic [3:0]  s_wstrb,       // AXI byte enables
    input  wire logic        s_wvalid,      // AXI
    output logic             s_wready,      // AXI
    output logic [1:0]       s_bresp,       // AXI
    output logic             s_bvalid,      // AXI
    input  wire logic        s_bready,      // AXI
    input  wire logic [7:0]  s_araddr,      // AXI read address
    input  wire logic        s_arvalid,     // AXI
    output logic             s_arready,     // AXI
    output logic [31:0]      s_rdata,       // AXI read data
    output logic [1:0]       s_rresp,       // AXI
    output logic             s_rvalid,      // AXI
    input  wire logic        s_rready,      // AXI
    output logic             host_irq       // IRQ5 seen by host
);
    pisb_hstate_t state, next_state;
    logic       aw_got, w_got, next_aw_got, next_w_got;
    logic [7:0] aw_addr, next_aw_addr;
    logic [7:0] w_byte, next_w_byte;
    logic       w_lane, next_w_lane;
    logic [1:0] stat, next_stat;
    logic [9:0] io_addr_q, next_io_addr;
    logic       io_wr_q, next_io_wr;
    logic       io_rd_q, next_io_rd;
    logic [7:0] io_wdata_q, next_io_wdata;
    logic       next_awready, next_wready, next_arready;
    logic       next_bvalid, next_rvalid, next_irq;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    assign bus.io_addr  = io_addr_q;
    assign bus.io_wr    = io_wr_q;
    assign bus.io_rd    = io_rd_q;
    assign bus.io_wdata = io_wdata_q;

    always_comb begin
        next_state = state;
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_aw_addr = aw_addr;
        next_w_byte = w_byte;
        next_w_lane = w_lane;
        next_stat = stat;
        next_io_addr = io_addr_q;
        next_io_wr = 1'b0;
        next_io_rd = 1'b0;
        next_io_wdata = io_wdata_q;
        next_bvalid = s_bvalid && !s_bready;
        next_bresp = s_bresp;
        next_rvalid = s_rvalid && !s_rready;
        next_rresp = s_rresp;
        next_rdata = s_rdata;
        next_irq = bus.irq5;
        if (s_awvalid && s_awready) begin
            next_aw_got = 1'b1;
            next_aw_addr = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            next_w_got = 1'b1;
            next_w_byte = s_wdata[7:0];
            next_w_lane = s_wstrb[0];
        end
        case (state)
            H_IDLE: begin
                if (aw_got && w_got) begin
                    next_aw_got = 1'b0;
                    next_w_got = 1'b0;
                    next_bvalid = 1'b1;
                    next_bresp = (aw_addr == REG_CMD || aw_addr == REG_STATUS)
                               ? RESP_OKAY : RESP_SLVERR;
                    if (aw_addr == REG_CMD && w_lane) begin
                        // Keys write, then status refresh
                        next_io_addr = KEYS_PORT;
                        next_io_wdata = w_byte;
                        next_io_wr = 1'b1;
                        next_state = H_WRITE;
                    end
                end else if (bus.irq5 && !host_irq) begin
                    next_io_addr = KEYS_PORT;
                    next_io_rd = 1'b1;
                    next_state = H_READ;
                end
            end
            H_WRITE: begin
                next_io_rd = 1'b1;
                next_state = H_READ;
            end
            H_READ: begin
                next_state = H_CAPT;
            end
            H_CAPT: begin
                next_stat = {bus.io_rdata[STAT_P2H], bus.io_rdata[STAT_H2P]};
                next_state = H_IDLE;
            end
            default: begin
                next_state = H_IDLE;
            end
        endcase
        if (s_arvalid && s_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            if (s_araddr == REG_STATUS) begin
                next_rdata = {28'h0000000, state != H_IDLE, host_irq, stat};
            end else if (s_araddr == REG_CMD) begin
                next_rdata = 32'h00000000;
            end else begin
                next_rdata = 32'h00000000;
                next_rresp = RESP_SLVERR;
            end
        end
        // Writes stall while the bus sequence runs
        next_awready = !next_aw_got && !next_bvalid && !(s_awvalid && s_awready);
        next_wready  = !next_w_got && !next_bvalid && !(s_wvalid && s_wready);
        next_arready = !next_rvalid && !(s_arvalid && s_arready);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= H_IDLE;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
            stat <= 2'h0;
            io_addr_q <= 10'h000;
            io_wr_q <= 1'b0;
            io_rd_q <= 1'b0;
            io_wdata_q <= 8'h00;
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_arready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
            s_rvalid <= 1'b0;
            s_rresp <= RESP_OKAY;
            s_rdata <= 32'h00000000;
            host_irq <= 1'b0;
        end else begin
            state <= next_state;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            aw_addr <= next_aw_addr;
            w_byte <= next_w_byte;
            w_lane <= next_w_lane;
            stat <= next_stat;
            io_addr_q <= next_io_addr;
            io_wr_q <= next_io_wr;
            io_rd_q <= next_io_rd;
            io_wdata_q <= next_io_wdata;
            s_awready <= next_awready;
            s_wready <= next_wready;
            s_arready <= next_arready;
            s_bvalid <= next_bvalid;
            s_bresp <= next_bresp;
            s_rvalid <= next_rvalid;
            s_rresp <= next_rresp;
            s_rdata <= next_rdata;
            host_irq <= next_irq;
        end
    end
endmodule : pisb_host
`default_nettype wire

// >>> pisb_sva.sv
`timescale 1ns/100ps
`default_nettype none
module pisb_sva
    import pisb_pkg::*;
(
    input wire logic       aclk,     // Clock
    input wire logic       aresetn,  // Reset, low
    input wire logic [9:0] io_addr,  // Port address
    input wire logic       io_wr,    // Key strobe
    input wire logic       io_rd,    // Status strobe
    input wire logic [7:0] io_wdata, // Keys byte
    input wire logic [7:0] io_rdata, // Status byte
    input wire logic       irq5      // Host interrupt
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_wr_port; io_wr |-> io_addr == KEYS_PORT; endproperty
    a_wr_port: assert property (p_wr_port) else $error("key write off port");
    property p_rd_port; io_rd |-> io_addr == KEYS_PORT; endproperty
    a_rd_port: assert property (p_rd_port) else $error("status read off port");
    property p_wr_pulse; io_wr |=> !io_wr; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("key strobe too long");
    property p_wr_rd; !(io_wr && io_rd); endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("write and read together");
    property p_p2h_set; io_wr && io_wdata[KEY_P2H_SET] |=> irq5; endproperty
    a_p2h_set: assert property (p_p2h_set) else $error("re-raise lost");
    property p_p2h_clr; $fell(irq5) |-> $past(io_wr) && $past(io_wdata[KEY_P2H_CLR]); endproperty
    a_p2h_clr: assert property (p_p2h_clr) else $error("irq5 dropped unasked");
    property p_stat_p2h; io_rd |=> io_rdata[STAT_P2H] == $past(irq5); endproperty
    a_stat_p2h: assert property (p_stat_p2h) else $error("status flag wrong");
    property p_h2p_set;
        io_wr && io_wdata[KEY_H2P_SET] ##1 io_rd |=> io_rdata[STAT_H2P];
    endproperty
    a_h2p_set: assert property (p_h2p_set) else $error("mailbox flag not shown");
endmodule : pisb_sva
`default_nettype wire

// >>> priority_interrupt_signal_box_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module priority_interrupt_signal_box_tb_top;
    import pisb_pkg::*;
    logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic [7:0]  s_awaddr, s_araddr, normal_src;
    logic [31:0] s_wdata, seed = 32'h5a;
    logic [3:0]  s_wstrb, ext_req;
    wire         s_awready, s_wready, s_bvalid, s_arready, s_rvalid, host_irq;
    wire [1:0]   s_bresp, s_rresp, service_route;
    wire [31:0]  s_rdata;
    logic run, rtc_tick, master_clear_switch, stop_mode, enable_wr, level_check, wait_cmd;
    logic ident_cmd, device_io_command, trap_ack, idb_read;
    logic proc_clears_h2p, proc_resets_h2p, proc_sets_p2h;
    logic [15:0] sw_detect_set, enable_data;
    logic [2:0]  dev_sel;
    logic [4:0]  bus_source_select;
    wire [3:0]   current_level_register, ident_code;
    wire level_change, interrupt_request_ff, host_to_proc_flag, proc_to_host_flag;
    wire [15:0]  level_detect_bits, level_enable_bits;
    wire [11:0]  trap_vector;
    wire [7:0]   idb_data;
    logic [34:0] exp_q[$], e_note;
    logic [7:0]  keys [3] = '{8'h04, 8'h06, 8'h04};
    logic [31:0] stat [3] = '{32'h1, 32'h7, 32'h1};
    int          num_errors, comparisons;
    pisb_if bus_if ();
    pisb_device pisb_device_inst (.aclk, .aresetn, .bus(bus_if), .ext_req, .normal_src, .run,
        .rtc_tick, .master_clear_switch, .stop_mode, .sw_detect_set, .enable_wr, .enable_data,
        .level_check, .wait_cmd, .ident_cmd, .device_io_command, .dev_sel, .trap_ack, .idb_read,
        .bus_source_select, .proc_clears_h2p, .proc_resets_h2p, .proc_sets_p2h,
        .current_level_register, .level_change, .level_detect_bits, .level_enable_bits,
        .interrupt_request_ff, .trap_vector, .ident_code, .idb_data, .service_route,
        .host_to_proc_flag, .proc_to_host_flag);
    pisb_host pisb_host_inst (.aclk, .aresetn, .bus(bus_if), .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
        .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .host_irq);
    pisb_sva pisb_sva_inst (.aclk, .aresetn, .io_addr(bus_if.io_addr), .io_wr(bus_if.io_wr),
        .io_rd(bus_if.io_rd), .io_wdata(bus_if.io_wdata), .io_rdata(bus_if.io_rdata),
        .irq5(bus_if.irq5));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic check(input logic [34:0] got, input logic [34:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic close_out();
        $display("Counts: %0d comparisons, %0d errors", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    // Expected note: {data compared, resp, data}; one transfer in flight at a time
    task automatic axi(input logic wr, input logic [7:0] a, input logic [7:0] k,
                       input logic [34:0] e);
        logic [4:0]  v;
        logic [31:0] r;
        r = rnd();
        v = wr ? 5'h1c : 5'h03;
        @(posedge aclk);
        exp_q.push_back(e);
        s_awaddr <= a;
        s_araddr <= a;
        s_wdata <= {r[31:8], k};
        for (int n = 0; n < 60; n++) begin
            {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= v;
            if (v == 5'h00) break;
            @(posedge aclk);
            v = v & ~{s_awready, s_wready, s_bvalid, s_arready, s_rvalid};
        end
        if (v != 5'h00) begin
            num_errors++;
            close_out();
        end
        if (wr) repeat (4) @(posedge aclk);
    endtask : axi
    always @(posedge aclk) begin
        if ((s_bvalid && s_bready) || (s_rvalid && s_rready)) begin
            e_note = exp_q.pop_front();
            check({e_note[34], s_bvalid ? s_bresp : s_rresp, e_note[34] ? s_rdata : 32'h0}, e_note);
        end
    end
    initial begin
        {ext_req, normal_src, rtc_tick, master_clear_switch, stop_mode, sw_detect_set} = '0;
        {enable_wr, enable_data, level_check, wait_cmd, ident_cmd, device_io_command} = '0;
        {dev_sel, trap_ack, idb_read, bus_source_select, proc_clears_h2p} = '0;
        {proc_resets_h2p, proc_sets_p2h, s_awaddr, s_araddr, s_wdata} = '0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, aresetn} = '0;
        s_wstrb = 4'h1;
        run = 1'b1;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axi(1, REG_CMD, 8'h01, {1'b0, RESP_OKAY, 32'h0});
        axi(0, REG_STATUS, 8'h00, {1'b1, RESP_OKAY, 32'h1});
        #1 check(host_to_proc_flag, 1'b1);
        @(posedge aclk);
        proc_clears_h2p <= 1'b1;
        @(posedge aclk);
        proc_clears_h2p <= 1'b0;
        #1 check(host_to_proc_flag, 1'b0);
        @(posedge aclk);
        {proc_clears_h2p, proc_resets_h2p} <= 2'h3;
        @(posedge aclk);
        {proc_clears_h2p, proc_resets_h2p, proc_sets_p2h} <= 3'h1;
        #1 check(host_to_proc_flag, 1'b1);
        @(posedge aclk);
        proc_sets_p2h <= 1'b0;
        #1 check(proc_to_host_flag, 1'b1);
        repeat (8) @(posedge aclk);
        axi(0, REG_STATUS, 8'h00, {1'b1, RESP_OKAY, 32'h7});
        for (int i = 0; i < 3; i++) begin
            axi(1, REG_CMD, keys[i], {1'b0, RESP_OKAY, 32'h0});
            axi(0, REG_STATUS, 8'h00, {1'b1, RESP_OKAY, stat[i]});
        end
        axi(1, 8'h10, 8'h01, {1'b0, RESP_SLVERR, 32'h0});
        axi(0, 8'h10, 8'h00, {1'b0, RESP_SLVERR, 32'h0});
        axi(0, REG_CMD, 8'h00, {1'b1, RESP_OKAY, 32'h0});
        @(posedge aclk);
        {enable_wr, ext_req} <= 5'h19;
        enable_data <= 16'(rnd()) | 16'h2400;
        @(posedge aclk);
        {enable_wr, ext_req, level_check} <= 6'h01;
        @(posedge aclk);
        level_check <= 1'b0;
        #1 check(level_change, 1'b1);
        @(posedge aclk);
        wait_cmd <= 1'b1;
        #1 check(current_level_register, LVL_RTC);
        check(level_enable_bits[LVL_RTC], 1'b1);
        @(posedge aclk);
        wait_cmd <= 1'b0;
        @(posedge aclk);
        #1 check(current_level_register, LVL_TERM_OUT);
        check(level_detect_bits, 16'(1) << LVL_TERM_OUT);
        @(posedge aclk);
        normal_src <= 8'(1 << SRC_DMA);
        proc_clears_h2p <= 1'b1;
        @(posedge aclk);
        {normal_src, proc_clears_h2p} <= 9'h000;
        {idb_read, ident_cmd, bus_source_select} <= {2'h3, SEL_NORMAL};
        @(posedge aclk);
        {idb_read, ident_cmd, trap_ack} <= 3'h1;
        #1 check(idb_data, {1'b1, 3'h0, 4'(SRC_DMA)});
        check(service_route, ROUTE_LINK);
        check(ident_code, 4'(SRC_DMA));
        check(interrupt_request_ff, 1'b1);
        check(trap_vector, NORMAL_VECTOR_BASE);
        @(posedge aclk);
        trap_ack <= 1'b0;
        #1 check(interrupt_request_ff, 1'b0);
        repeat (4) @(posedge aclk);
        if (exp_q.size() != 0) num_errors++;
        close_out();
    end
endmodule : priority_interrupt_signal_box_tb_top
`default_nettype wire
